// [bbc_assertions.sv]
`timescale 1ns/1ns
module bbc_checker (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Sequencing inputs
	input wire logic       controller_not_busy,
	input wire logic       order_out,
	input wire logic       transfer_phase_strobe,
	// Buffer state
	input wire logic [3:0] location_select,
	input wire logic       buffer_idle,
	input wire logic       cycle_launch,
	input wire logic       write_cycle,
	input wire logic       read_cycle,
	input wire logic       write_pointer_clock,
	input wire logic       read_pointer_clock,
	input wire logic       memory_clock_enable,
	input wire logic       occupancy_full_bit,
	input wire logic       buffer_empty,
	input wire logic [4:0] occupancy,
	input wire logic       output_load
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [4:0] occ_q;
	// Count held from launch, so a whole cycle must net exactly one step
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			occ_q <= 5'h00;
		end else if (cycle_launch && buffer_idle) begin
			occ_q <= occupancy;
		end
	end
	// ****************************************************************
	// Cycle shapes
	// ****************************************************************
	sequence s_quiet;
		!buffer_idle [*8];
	endsequence
	sequence s_wr_end;
		$fell(write_cycle) && !controller_not_busy;
	endsequence
	sequence s_rd_end;
		$fell(read_cycle) && !controller_not_busy;
	endsequence
	chk_idle_loc_zero: assert property (buffer_idle && $past(buffer_idle) |-> location_select == 4'h0)
		else $error("location select not zero while idle");
	chk_cycle_span: assert property ($fell(buffer_idle) |-> s_quiet ##1 s_quiet ##1 s_quiet ##[4:7] buffer_idle)
		else $error("buffer cycle length wrong");
	chk_not_busy: assert property (controller_not_busy ##1 controller_not_busy |-> buffer_idle)
		else $error("buffer active while controller not busy");
	chk_wr_count: assert property (s_wr_end |-> occupancy == occ_q + 5'h01)
		else $error("occupancy not raised by write cycle");
	chk_rd_count: assert property (s_rd_end |-> occupancy == occ_q - 5'h01)
		else $error("occupancy not lowered by read cycle");
	chk_full_empty: assert property (occupancy_full_bit == occupancy[4] && buffer_empty == (occupancy == 5'h00))
		else $error("full or empty decode wrong");
	chk_order_clr: assert property (order_out && transfer_phase_strobe |=> occupancy inside {5'h00, 5'h10})
		else $error("order-out did not reload occupancy");
	chk_launch_idle: assert property ($rose(cycle_launch) |-> buffer_idle)
		else $error("launch while buffer active");
	chk_wr_prio: assert property (write_cycle |-> !read_cycle)
		else $error("read and write cycle together");
	chk_gate_drop: assert property ($rose(cycle_launch) && !controller_not_busy |-> ##[12:16] !cycle_launch)
		else $error("request gates not cleared at tap 110");
	chk_latch_set: assert property ($rose(cycle_launch) && !controller_not_busy |-> ##[4:7]
		($rose(write_cycle) || $rose(read_cycle)))
		else $error("cycle latch not set at tap 40");
	chk_ptr_pulse: assert property (write_pointer_clock |-> write_cycle ##1 !write_pointer_clock)
		else $error("write pointer clock outside write cycle");
	chk_rptr_pulse: assert property (read_pointer_clock |-> read_cycle ##1 !read_pointer_clock)
		else $error("read pointer clock outside read cycle");
	chk_store_en: assert property (memory_clock_enable |-> write_cycle)
		else $error("store enable outside write cycle");
	chk_load_rd: assert property (output_load |-> read_cycle)
		else $error("output load outside read cycle");
endmodule
bind bbc_byte_buffer_control bbc_checker bbc_checker_inst (.sys_clk, .rst, .controller_not_busy, .order_out,
	.transfer_phase_strobe, .location_select, .buffer_idle, .cycle_launch, .write_cycle, .read_cycle,
	.write_pointer_clock, .read_pointer_clock, .memory_clock_enable, .occupancy_full_bit, .buffer_empty,
	.occupancy, .output_load);

// [bbc_byte_buffer_control.sv]
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Order-out transfer strobe clears write and read pointers to zero.
// - Write pointer steps after tap 130 of write cycle; read pointer likewise.
// - Location select follows cycle's pointer; forced zero while idle.
// - Leave idle at tap 60, return at tap 300; idle while not busy.
// - Occupancy counts up per write cycle, down per read cycle.
// - Full is the occupancy counter's top stage.
// - Empty when occupancy counter is all zeros.
// - Order-out clears occupancy; test-mode-1 host-bound order sets full instead.
// - Upper stages clock at tap 110; low stage about 20 ns later.
// - Timing cycle launches on cycle launch only while idle.
// - Launch when either gate set; write wins when both are set.
// - Gate clearing overrides setting; gates enabled only with buffer enable.
// - Launch blocks further gate setting; gates cleared at tap 110.
// - Write or read cycle latch set from granted gate at tap 40.
// - Write requested only with input register full and buffer idle.
// - Test mode 1 host data: writes regardless; store inhibited after 16 bytes.
// - Normal write needs not full and read order, empty, or output full.
// - Read requires idle, output register empty, not empty, no inhibit.
// - Read inhibited by read order pending, test-mode-1 write, wide end data.
// - Byte written to addressed location at tap 180 with clock enable.
// - Addressed byte loads output holding register at tap 200 of read.
// - Buffer enable set in data service; cleared by start-I/O clear or order-in.
module bbc_byte_buffer_control (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// Register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	// Controller sequencing
	input  wire logic                   controller_not_busy,
	input  wire logic                   order_out,
	input  wire logic                   transfer_phase_strobe,
	input  wire logic                   data_service_cycle,
	input  wire logic                   order_in_service,
	input  wire logic                   start_io_clear,
	input  wire logic                   data_in_service,
	input  wire logic                   end_data_latch,
	// Holding registers
	input  wire logic                   input_reg_full,
	input  wire logic                   output_reg_full,
	input  wire logic [7:0]             input_byte,
	// Buffer state
	output logic      [3:0]             location_select,
	output logic                        buffer_idle,
	output logic                        cycle_launch,
	output logic                        write_cycle,
	output logic                        read_cycle,
	output logic                        write_pointer_clock,
	output logic                        read_pointer_clock,
	output logic                        memory_clock_enable,
	output logic                        occupancy_full_bit,
	output logic                        buffer_empty,
	output logic      [4:0]             occupancy,
	// Output byte
	output logic      [7:0]             output_byte,
	output logic                        output_load
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [2:0]                     ctrl_q;
	logic                           test_mode_one, host_to_ctrl_order, ctrl_to_host_order, wide_interface;
	logic [3:0]                     wptr_q, rptr_q, occ_hi_q, loc_q;
	logic                           occupancy_low_bit, buffer_active_latch, buffer_en_q, clken_inhibit_q;
	logic                           write_cycle_q, read_cycle_q, out_load_q;
	logic [7:0]                     out_byte_q;
	logic [31:0]                    rdata_q;
	logic [7:0]                     staging_memory [16];
	bbc_pkg::bbc_tstate_t           tstate_q;
	logic [5:0]                     tap_q;
	logic                           write_request_gate, read_request_gate, write_grant, read_grant;
	logic                           write_set, read_set, read_inhibit;
	logic                           pointer_clear_clock, gate_clear, launch_go;
	logic                           tap_forty_delayed, tap_sixty, tap_one_ten, tap_one_thirty, tap_low;
	logic                           tap_one_eighty, tap_two_hundred, tap_three_hundred;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	assign test_mode_one      = ctrl_q[bbc_pkg::CTRL_TM1_BIT];
	assign host_to_ctrl_order = ctrl_q[bbc_pkg::CTRL_HOST_TO_CTRL_ORDER_BIT];
	assign ctrl_to_host_order = !host_to_ctrl_order;
	assign wide_interface     = ctrl_q[bbc_pkg::CTRL_WIDE_BIT];

	// Software writes the mode bits that steer the start-up logic
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= bbc_pkg::CTRL_RESET;
		end else if (reg_wr && reg_addr == bbc_pkg::CTRL_OFFSET) begin
			ctrl_q <= reg_wdata[2:0];
		end
	end

	// Read data stands one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (reg_rd && reg_addr == bbc_pkg::CTRL_OFFSET) begin
				rdata_q[2:0] <= ctrl_q;
			end else if (reg_rd && reg_addr == bbc_pkg::STATUS_OFFSET) begin
				rdata_q[bbc_pkg::ST_OCC_LSB +: 5]  <= occupancy;
				rdata_q[bbc_pkg::ST_WPTR_LSB +: 4] <= wptr_q;
				rdata_q[bbc_pkg::ST_RPTR_LSB +: 4] <= rptr_q;
				rdata_q[bbc_pkg::ST_FULL_BIT]      <= occupancy_full_bit;
				rdata_q[bbc_pkg::ST_EMPTY_BIT]     <= buffer_empty;
				rdata_q[bbc_pkg::ST_IDLE_BIT]      <= buffer_idle;
				rdata_q[bbc_pkg::ST_WCYC_BIT]      <= write_cycle_q;
				rdata_q[bbc_pkg::ST_RCYC_BIT]      <= read_cycle_q;
				rdata_q[bbc_pkg::ST_CLKEN_BIT]     <= memory_clock_enable;
				rdata_q[bbc_pkg::ST_BUFEN_BIT]     <= buffer_en_q;
			end
		end
	end
	assign reg_rdata = rdata_q;

	// ****************************************************************
	// Delay-line model: a tap counter running from launch
	// ****************************************************************
	assign launch_go = cycle_launch && tstate_q == bbc_pkg::BBC_IDLE && buffer_idle
		&& !controller_not_busy;

	// A not-busy controller aborts the cycle so the buffer sits idle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tstate_q <= bbc_pkg::BBC_IDLE;
			tap_q    <= 6'h00;
		end else begin
			case (tstate_q)
				bbc_pkg::BBC_IDLE: begin
					tap_q <= 6'h00;
					if (launch_go) begin
						tstate_q <= bbc_pkg::BBC_RUN;
						tap_q    <= 6'h01;
					end
				end
				bbc_pkg::BBC_RUN: begin
					if (controller_not_busy || tap_three_hundred) begin
						tstate_q <= bbc_pkg::BBC_IDLE;
						tap_q    <= 6'h00;
					end else begin
						tap_q <= tap_q + 6'h01;
					end
				end
				default: begin
					tstate_q <= bbc_pkg::BBC_IDLE;
					tap_q    <= 6'h00;
				end
			endcase
		end
	end

	// One-cycle tap pulses; each fires once per timing cycle
	assign tap_forty_delayed = tap_q == 6'(bbc_pkg::TAP_040_CYC);
	assign tap_sixty         = tap_q == 6'(bbc_pkg::TAP_060_CYC);
	assign tap_one_ten       = tap_q == 6'(bbc_pkg::TAP_110_CYC);
	assign tap_one_thirty    = tap_q == 6'(bbc_pkg::TAP_130_CYC);
	assign tap_low           = tap_q == 6'(bbc_pkg::TAP_LOW_CYC);
	assign tap_one_eighty    = tap_q == 6'(bbc_pkg::TAP_180_CYC);
	assign tap_two_hundred   = tap_q == 6'(bbc_pkg::TAP_200_CYC);
	assign tap_three_hundred = tap_q == 6'(bbc_pkg::TAP_300_CYC);

	// Buffer in use from tap 60 to tap 300; not-busy holds it at rest
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buffer_active_latch <= 1'b0;
		end else if (controller_not_busy) begin
			buffer_active_latch <= 1'b0;
		end else if (tap_sixty) begin
			buffer_active_latch <= 1'b1;
		end else if (tap_three_hundred) begin
			buffer_active_latch <= 1'b0;
		end
	end
	assign buffer_idle = !buffer_active_latch;

	// ****************************************************************
	// Buffer enable latch
	// ****************************************************************
	// Set beats clear so a data service in the clearing cycle is kept
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buffer_en_q <= 1'b0;
		end else if (data_service_cycle) begin
			buffer_en_q <= 1'b1;
		end else if (start_io_clear || order_in_service) begin
			buffer_en_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Start-up logic
	// ****************************************************************
	// Read inhibit keeps the holding registers flowing the right way
	assign read_inhibit = (ctrl_to_host_order && input_reg_full && !occupancy_full_bit)
		|| (test_mode_one && host_to_ctrl_order)
		|| (wide_interface && data_in_service && end_data_latch);

	// Test mode 1 host data ignores occupancy; normal mode needs room
	assign write_set = input_reg_full && buffer_idle
		&& ((test_mode_one && host_to_ctrl_order)
		|| (!occupancy_full_bit && (ctrl_to_host_order || buffer_empty || output_reg_full)));

	assign read_set = buffer_idle && !output_reg_full && !buffer_empty && !read_inhibit;

	assign gate_clear = tap_one_ten;

	bbc_request_gate u_write_gate (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_req (write_set),
		.clear   (gate_clear),
		.enable  (buffer_en_q),
		.block   (cycle_launch),
		.gate_q  (write_request_gate)
	);

	bbc_request_gate u_read_gate (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_req (read_set),
		.clear   (gate_clear),
		.enable  (buffer_en_q),
		.block   (cycle_launch),
		.gate_q  (read_request_gate)
	);

	// Write grant suppresses read grant but never the launch itself
	assign cycle_launch = write_request_gate || read_request_gate;
	assign write_grant  = write_request_gate;
	assign read_grant   = read_request_gate && !write_request_gate;

	// Cycle latches steer transfers from tap 40 to the end of the cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			write_cycle_q <= 1'b0;
			read_cycle_q  <= 1'b0;
		end else if (tap_three_hundred || controller_not_busy) begin
			write_cycle_q <= 1'b0;
			read_cycle_q  <= 1'b0;
		end else if (tap_forty_delayed) begin
			write_cycle_q <= write_grant;
			read_cycle_q  <= read_grant;
		end
	end
	assign write_cycle = write_cycle_q;
	assign read_cycle  = read_cycle_q;

	// ****************************************************************
	// Address pointers and location select
	// ****************************************************************
	assign pointer_clear_clock = order_out && transfer_phase_strobe;
	assign write_pointer_clock = write_cycle_q && tap_one_thirty;
	assign read_pointer_clock  = read_cycle_q && tap_one_thirty;

	// Four-bit counters wrap naturally, giving a circular store
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wptr_q <= bbc_pkg::PTR_RESET;
			rptr_q <= bbc_pkg::PTR_RESET;
		end else if (pointer_clear_clock) begin
			wptr_q <= bbc_pkg::PTR_RESET;
			rptr_q <= bbc_pkg::PTR_RESET;
		end else if (buffer_en_q) begin
			if (write_pointer_clock) begin
				wptr_q <= wptr_q + 4'h1;
			end
			if (read_pointer_clock) begin
				rptr_q <= rptr_q + 4'h1;
			end
		end
	end

	// Select latched at tap 60 and held: pointers step at tap 130, before the store
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			loc_q <= bbc_pkg::PTR_RESET;
		end else if (tap_sixty && !controller_not_busy) begin
			loc_q <= write_cycle_q ? wptr_q : rptr_q;
		end else if (buffer_idle) begin
			loc_q <= bbc_pkg::PTR_RESET;
		end
	end
	assign location_select = loc_q;

	// ****************************************************************
	// Occupancy counter
	// ****************************************************************
	// Upper stages move at tap 110 using the low stage as carry or borrow
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			occ_hi_q <= 4'h0;
		end else if (pointer_clear_clock) begin
			occ_hi_q <= (test_mode_one && ctrl_to_host_order) ? bbc_pkg::OCC_FULL[4:1]
				: bbc_pkg::OCC_RESET[4:1];
		end else if (tap_one_ten && write_cycle_q && occupancy_low_bit) begin
			occ_hi_q <= occ_hi_q + 4'h1;
		end else if (tap_one_ten && read_cycle_q && !occupancy_low_bit) begin
			occ_hi_q <= occ_hi_q - 4'h1;
		end
	end

	// Low stage lags so the carry decision above sees it stable
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			occupancy_low_bit <= 1'b0;
		end else if (pointer_clear_clock) begin
			occupancy_low_bit <= 1'b0;
		end else if (tap_low && (write_cycle_q || read_cycle_q)) begin
			occupancy_low_bit <= !occupancy_low_bit;
		end
	end

	assign occupancy          = {occ_hi_q, occupancy_low_bit};
	assign occupancy_full_bit = occ_hi_q[3];
	assign buffer_empty       = occupancy == bbc_pkg::OCC_RESET;

	// ****************************************************************
	// Staging memory and output byte
	// ****************************************************************
	// Store inhibit latches at cycle end once test mode 1 fills the buffer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clken_inhibit_q <= 1'b0;
		end else if (tap_three_hundred && occupancy_full_bit && test_mode_one) begin
			clken_inhibit_q <= 1'b1;
		end else if (order_out) begin
			clken_inhibit_q <= 1'b0;
		end
	end
	assign memory_clock_enable = write_cycle_q && !clken_inhibit_q;

	// Later bytes are still accepted, only the store is dropped
	always_ff @(posedge sys_clk) begin
		if (tap_one_eighty && memory_clock_enable) begin
			staging_memory[loc_q] <= input_byte;
		end
	end

	// Holding register load; load pulse tells the owner it is now full
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_byte_q <= 8'h00;
			out_load_q <= 1'b0;
		end else begin
			out_load_q <= 1'b0;
			if (tap_two_hundred && read_cycle_q) begin
				out_byte_q <= staging_memory[loc_q];
				out_load_q <= 1'b1;
			end
		end
	end
	assign output_byte = out_byte_q;
	assign output_load = out_load_q;

endmodule

// [bbc_partner.sv]
`timescale 1ns/1ns
module bbc_partner (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Bench handles
	input  wire logic       feed,
	input  wire logic [7:0] feed_byte,
	input  wire logic       drain,
	// Block side
	input  wire logic       write_pointer_clock,
	input  wire logic       write_cycle,
	input  wire logic       output_load,
	output logic            input_reg_full,
	output logic            output_reg_full,
	output logic [7:0]      input_byte
);
	// Input register: byte held through its store, churns once released
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			input_reg_full <= 1'b0;
			input_byte <= 8'h00;
		end else if (feed) begin
			input_reg_full <= 1'b1;
			input_byte <= feed_byte;
		end else if (write_pointer_clock) begin
			input_reg_full <= 1'b0;
		end else if (!input_reg_full && !write_cycle) begin
			input_byte <= input_byte + 8'h5B;
		end
	end
	// Output register: filled by the block, emptied when the bench drains
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			output_reg_full <= 1'b0;
		end else if (output_load) begin
			output_reg_full <= 1'b1;
		end else if (drain) begin
			output_reg_full <= 1'b0;
		end
	end
endmodule

// [bbc_pkg.sv]
package bbc_pkg;

	// ****************************************************************
	// Clock and delay-line taps
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int TAP_040_NS    = 40;
	localparam int TAP_060_NS    = 60;
	localparam int TAP_110_NS    = 110;
	localparam int TAP_130_NS    = 130;
	localparam int LOW_LAG_NS    = 20;
	localparam int TAP_180_NS    = 180;
	localparam int TAP_200_NS    = 200;
	localparam int TAP_300_NS    = 300;

	// Taps are events after launch, so round up to whole cycles
	localparam int TAP_040_CYC = (TAP_040_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_060_CYC = (TAP_060_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_110_CYC = (TAP_110_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_130_CYC = (TAP_130_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_LOW_CYC = (TAP_110_NS + LOW_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_180_CYC = (TAP_180_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_200_CYC = (TAP_200_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_300_CYC = (TAP_300_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_CNT_W   = 6;

	// ****************************************************************
	// Buffer geometry
	// ****************************************************************
	localparam int BUF_DEPTH = 16;
	localparam int PTR_W     = 4;
	localparam int OCC_W     = 5;
	localparam int BYTE_W    = 8;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 32;
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [2:0] CTRL_RESET    = 3'h0;
	localparam int CTRL_TM1_BIT   = 0;
	localparam int CTRL_HOST_TO_CTRL_ORDER_BIT  = 1;
	localparam int CTRL_WIDE_BIT  = 2;
	localparam int ST_OCC_LSB     = 0;
	localparam int ST_WPTR_LSB    = 8;
	localparam int ST_RPTR_LSB    = 12;
	localparam int ST_FULL_BIT    = 16;
	localparam int ST_EMPTY_BIT   = 17;
	localparam int ST_IDLE_BIT    = 18;
	localparam int ST_WCYC_BIT    = 19;
	localparam int ST_RCYC_BIT    = 20;
	localparam int ST_CLKEN_BIT   = 21;
	localparam int ST_BUFEN_BIT   = 22;

	// ****************************************************************
	// Reset and order-out load values
	// ****************************************************************
	localparam logic [4:0] OCC_RESET  = 5'h00;
	localparam logic [4:0] OCC_FULL   = 5'h10;
	localparam logic [3:0] PTR_RESET  = 4'h0;

	typedef enum logic [1:0] {
		BBC_IDLE,
		BBC_RUN
	} bbc_tstate_t;

endpackage

// [bbc_request_gate.sv]
`timescale 1ns/1ns
// Rejection-style latch: the clearing input overrides setting inputs
module bbc_request_gate (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Control
	input  wire logic set_req,
	input  wire logic clear,
	input  wire logic enable,
	input  wire logic block,
	// State
	output logic      gate_q
);

	// Clear or missing enable beats any set; set is refused once launch is up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gate_q <= 1'b0;
		end else if (clear || !enable) begin
			gate_q <= 1'b0;
		end else if (set_req && !block) begin
			gate_q <= 1'b1;
		end
	end

endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	logic        sys_clk, rst, reg_wr, reg_rd, feed, drain, controller_not_busy, order_out;
	logic        transfer_phase_strobe, data_service_cycle, order_in_service, input_reg_full, output_reg_full;
	logic        buffer_idle, cycle_launch, write_cycle, read_cycle, wpc, occupancy_full_bit, buffer_empty, output_load;
	logic [7:0]  reg_addr, feed_byte, seed, input_byte, output_byte;
	logic [31:0] reg_wdata, reg_rdata, rdat;
	logic [4:0]  occupancy;
	logic [7:0]  exp_q[$];
	int          fail_count, n_checks;
	bbc_byte_buffer_control bbc_byte_buffer_control_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .controller_not_busy, .order_out, .transfer_phase_strobe, .data_service_cycle,
		.order_in_service, .start_io_clear(1'b0), .data_in_service(1'b0), .end_data_latch(1'b0), .input_reg_full,
		.output_reg_full, .input_byte, .location_select(), .buffer_idle, .cycle_launch, .write_cycle, .read_cycle,
		.write_pointer_clock(wpc), .read_pointer_clock(), .memory_clock_enable(), .occupancy_full_bit,
		.buffer_empty, .occupancy, .output_byte, .output_load);
	bbc_partner bbc_partner_inst (.sys_clk, .rst, .feed, .feed_byte, .drain, .write_pointer_clock(wpc), .write_cycle,
		.output_load, .input_reg_full, .output_reg_full, .input_byte);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		rdat = reg_rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Quiet means idle with no gate up for four edges; bounded so a hang fails
	task automatic settle();
		int q;
		q = 0;
		for (int i = 0; i < 600 && q < 4; i++) begin
			@(posedge sys_clk);
			q = (buffer_idle && !cycle_launch) ? q + 1 : 0;
		end
		if (q < 4) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic give();
		settle();
		seed = lfsr(seed);
		exp_q.push_back(seed);
		feed <= 1'b1;
		feed_byte <= seed;
		@(posedge sys_clk);
		feed <= 1'b0;
	endtask
	task automatic pulse_drain();
		@(posedge sys_clk);
		drain <= 1'b1;
		@(posedge sys_clk);
		drain <= 1'b0;
		settle();
	endtask
	// Every byte leaving the buffer must be the oldest one fed in
	always @(posedge sys_clk) begin
		if (output_load) begin
			chk(output_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hFF);
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst, reg_wr, reg_rd, feed, drain, order_out, transfer_phase_strobe} = 7'h40;
		{data_service_cycle, order_in_service, controller_not_busy} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		feed_byte = 8'h00;
		seed = 8'h2C;
		fail_count = 0;
		n_checks = 0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(buffer_idle, 1'b1);
		chk(buffer_empty, 1'b1);
		rd(8'h08);
		chk(rdat, 32'h0);
		wr(bbc_pkg::CTRL_OFFSET, 32'h2);
		data_service_cycle <= 1'b1;
		@(posedge sys_clk);
		data_service_cycle <= 1'b0;
		// One byte parks in the output register, sixteen fill the buffer, one waits
		for (int i = 0; i < 17; i++) begin
			give();
		end
		settle();
		chk(occupancy, 5'h10);
		chk(occupancy_full_bit, 1'b1);
		give();
		repeat (60) @(posedge sys_clk);
		chk(occupancy, 5'h10);
		chk(input_reg_full, 1'b1);
		for (int i = 0; i < 20; i++) begin
			pulse_drain();
		end
		chk(exp_q.size(), 32'h0);
		chk(buffer_empty, 1'b1);
		rd(bbc_pkg::STATUS_OFFSET);
		chk(rdat[15:8], 8'h22);
		$display("fill and drain test done");
		// Enable dropped by order-in: reloaded full count must not start reads
		order_in_service <= 1'b1;
		@(posedge sys_clk);
		order_in_service <= 1'b0;
		wr(bbc_pkg::CTRL_OFFSET, 32'h1);
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk);
			{order_out, transfer_phase_strobe} <= 2'h3;
			@(posedge sys_clk);
			{order_out, transfer_phase_strobe} <= 2'h0;
			repeat (40) @(posedge sys_clk);
			chk(occupancy, m == 0 ? 5'h10 : 5'h00);
			rd(bbc_pkg::STATUS_OFFSET);
			chk(rdat[15:8], 8'h00);
			wr(bbc_pkg::CTRL_OFFSET, 32'h0);
		end
		$display("order-out test done");
		// A waiting byte must not be taken while the controller is not busy
		wr(bbc_pkg::CTRL_OFFSET, 32'h2);
		data_service_cycle <= 1'b1;
		controller_not_busy <= 1'b1;
		@(posedge sys_clk);
		data_service_cycle <= 1'b0;
		give();
		repeat (60) @(posedge sys_clk);
		chk(buffer_idle, 1'b1);
		chk(occupancy, 5'h00);
		controller_not_busy <= 1'b0;
		settle();
		chk(output_reg_full, 1'b1);
		chk(exp_q.size(), 32'h0);
		$display("not busy test done");
		wrap_up();
	end
endmodule
